// ---- hw/vicpn_pkg.sv ----
package vicpn_pkg;

  // Sizes
  localparam int NUM_SRC = 28;                       // Interrupt sources
  localparam int LVL_W   = 3;                        // Priority level width
  localparam int IDX_W   = 5;                        // Source index width
  localparam int NUM_LVL = 8;                        // Levels per kind
  localparam int BASE_W  = 16;                       // Vector base width
  localparam int NUM_K   = 2;                        // Normal and fast kinds
  localparam int K_IRQ   = 0;                        // Normal kind index
  localparam int K_FIQ   = 1;                        // Fast kind index

  // Register byte addresses
  localparam logic [31:0] ADDR_BASE  = 32'hffff_0014; // vector_table_base
  localparam logic [31:0] ADDR_IVEC  = 32'hffff_001c; // normal_vector_address
  localparam logic [31:0] ADDR_PRIO2 = 32'hffff_0028; // priority_sources_set_two
  localparam logic [31:0] ADDR_PRIO3 = 32'hffff_002c; // priority_sources_set_three
  localparam logic [31:0] ADDR_NEST  = 32'hffff_0030; // nesting_control
  localparam logic [31:0] ADDR_ISTAN = 32'hffff_003c; // normal_level_in_service
  localparam logic [31:0] ADDR_FVEC  = 32'hffff_011c; // fast_vector_address
  localparam logic [31:0] ADDR_FSTAN = 32'hffff_013c; // fast_level_in_service

  // Per-kind addresses, index 0 normal, index 1 fast
  localparam logic [NUM_K-1:0][31:0] ADDR_VEC  = {ADDR_FVEC, ADDR_IVEC};
  localparam logic [NUM_K-1:0][31:0] ADDR_STAN = {ADDR_FSTAN, ADDR_ISTAN};

  // Reset values
  localparam logic [31:0]       RST_PRIO  = 32'h0000_0000;
  localparam logic [BASE_W-1:0] RST_BASE  = 16'h0000;
  localparam logic [1:0]        RST_NEST  = 2'h0;
  localparam logic [7:0]        RST_STAN  = 8'h00;

  // Writable field masks, reserved bits read zero
  localparam logic [31:0] PRIO2_MASK = 32'h7777_7777;
  localparam logic [31:0] PRIO3_MASK = 32'h0000_0077;

  // Field positions in the priority registers
  localparam int P2_PIN3_LSB = 28;                   // ext_pin3_priority
  localparam int P2_PIN2_LSB = 24;                   // ext_pin2_priority
  localparam int P2_LA0_LSB  = 20;                   // logic_array0_priority
  localparam int P2_PIN1_LSB = 16;                   // ext_pin1_priority
  localparam int P2_PSM_LSB  = 12;                   // supply_monitor_priority
  localparam int P2_CMP_LSB  = 8;                    // comparator_priority
  localparam int P2_PIN0_LSB = 4;                    // ext_pin0_priority
  localparam int P2_SPI_LSB  = 0;                    // serial_periph_priority
  localparam int P3_PWM_LSB  = 4;                    // pulse_width_priority
  localparam int P3_LA1_LSB  = 0;                    // logic_array1_priority

  // Nesting control bits
  localparam int NEST_IRQ_BIT = 0;                   // normal_nesting_enable
  localparam int NEST_FIQ_BIT = 1;                   // fast_nesting_enable

  // Vector word layout
  localparam int VEC_IDX_LSB  = 2;
  localparam int VEC_BASE_LSB = 7;

  // Source index of each prioritised source
  localparam int SRC_TIMER2 = 4;
  localparam int SRC_PIN0   = 13;
  localparam int SRC_CMP    = 14;
  localparam int SRC_PSM    = 15;
  localparam int SRC_PIN1   = 16;
  localparam int SRC_LA0    = 17;
  localparam int SRC_PIN2   = 18;
  localparam int SRC_PIN3   = 19;
  localparam int SRC_SPI    = 20;
  localparam int SRC_PWM    = 21;
  localparam int SRC_LA1    = 22;

  // Winner of one arbitration
  typedef struct packed {
    logic             valid;                         // Some source wins
    logic [LVL_W-1:0] level;                         // Its priority level
    logic [IDX_W-1:0] idx;                           // Its source index
  } vicpn_sel_t;

endpackage : vicpn_pkg

// ---- hw/vicpn_top.sv ----
`timescale 1ns/1ps
module vicpn_top (
  input  wire logic                                        core_clk,
  input  wire logic                                        sys_rst,
  input  wire logic                                        psel,
  input  wire logic                                        penable,
  input  wire logic                                        pwrite,
  input  wire logic [31:0]                                 paddr,
  input  wire logic [31:0]                                 pwdata,
  output logic      [31:0]                                 prdata,
  output logic                                             pready,
  output logic                                             pslverr,
  input  wire logic [vicpn_pkg::NUM_SRC-1:0]               irq_req,
  input  wire logic [vicpn_pkg::NUM_SRC-1:0]               fiq_req,
  input  wire logic [vicpn_pkg::NUM_SRC*vicpn_pkg::LVL_W-1:0] other_prio,
  output logic                                             core_irq,
  output logic                                             core_fiq
);

  // Register state
  logic [31:0]                          prio2_q;      // priority_sources_set_two
  logic [31:0]                          prio3_q;      // priority_sources_set_three
  logic [vicpn_pkg::BASE_W-1:0]         base_q;       // vector_table_base
  logic [1:0]                           nest_q;       // nesting_control
  logic [vicpn_pkg::NUM_K-1:0][7:0]     stan_q;       // In-service per kind
  logic [vicpn_pkg::NUM_K-1:0][7:0]     stan_d;       // Next in-service
  logic [vicpn_pkg::NUM_SRC*vicpn_pkg::LVL_W-1:0] src_lvl; // Level of each source
  vicpn_pkg::vicpn_sel_t [vicpn_pkg::NUM_K-1:0] sel;  // Live winners
  vicpn_pkg::vicpn_sel_t [vicpn_pkg::NUM_K-1:0] cap_q; // Winners at setup
  logic [vicpn_pkg::NUM_K-1:0][31:0]    vec;          // Vector words
  logic                                 setup;        // APB setup phase
  logic                                 wr_acc;       // Write access edge
  logic                                 rd_acc;       // Read access edge
  logic                                 core_irq_q;   // Normal line
  logic                                 core_fiq_q;   // Fast line

  // APB phases; the slave answers in the first access cycle
  assign setup  = psel && !penable;
  assign pready = psel && penable;
  assign wr_acc = pready && pwrite;
  assign rd_acc = pready && !pwrite;

  // Arbitrate one kind: blocking, priority and index tie break
  function automatic vicpn_pkg::vicpn_sel_t pick(
    input logic [vicpn_pkg::NUM_SRC-1:0]                  req,
    input logic [vicpn_pkg::NUM_SRC*vicpn_pkg::LVL_W-1:0] lv,
    input logic                                           nest,
    input logic [7:0]                                     stan
  );
    vicpn_pkg::vicpn_sel_t      s;
    logic [vicpn_pkg::LVL_W-1:0] l;
    logic [vicpn_pkg::LVL_W-1:0] thr;
    s   = '0;
    thr = '0;
    // Lowest set in-service level is the blocking threshold
    for (int j = vicpn_pkg::NUM_LVL - 1; j >= 0; j--)
    begin
      if (stan[j])
      begin
        thr = vicpn_pkg::LVL_W'(j);
      end
    end
    // Descending scan so the lowest index wins ties
    for (int i = vicpn_pkg::NUM_SRC - 1; i >= 0; i--)
    begin
      l = lv[i*vicpn_pkg::LVL_W +: vicpn_pkg::LVL_W];
      if (req[i] && (!nest || stan == '0 || l < thr)
          && (!nest || !s.valid || l <= s.level))
      begin
        s.valid = 1'b1;
        s.level = l;
        s.idx   = vicpn_pkg::IDX_W'(i);
      end
    end
    return s;
  endfunction : pick

  // Per-source level: held fields or levels from the other_prio input
  for (genvar g = 0; g < vicpn_pkg::NUM_SRC; g++)
  begin : g_lvl
    if (g == vicpn_pkg::SRC_PIN3)
    begin : g_p3
      assign src_lvl[g*3 +: 3] = prio2_q[vicpn_pkg::P2_PIN3_LSB +: 3];
    end
    else if (g == vicpn_pkg::SRC_PIN2)
    begin : g_p2
      assign src_lvl[g*3 +: 3] = prio2_q[vicpn_pkg::P2_PIN2_LSB +: 3];
    end
    else if (g == vicpn_pkg::SRC_PIN1)
    begin : g_p1
      assign src_lvl[g*3 +: 3] = prio2_q[vicpn_pkg::P2_PIN1_LSB +: 3];
    end
    else if (g == vicpn_pkg::SRC_PIN0)
    begin : g_p0
      assign src_lvl[g*3 +: 3] = prio2_q[vicpn_pkg::P2_PIN0_LSB +: 3];
    end
    else if (g == vicpn_pkg::SRC_LA0)
    begin : g_la0
      assign src_lvl[g*3 +: 3] = prio2_q[vicpn_pkg::P2_LA0_LSB +: 3];
    end
    else if (g == vicpn_pkg::SRC_SPI)
    begin : g_spi
      assign src_lvl[g*3 +: 3] = prio2_q[vicpn_pkg::P2_SPI_LSB +: 3];
    end
    else if (g == vicpn_pkg::SRC_PSM)
    begin : g_psm
      assign src_lvl[g*3 +: 3] = prio2_q[vicpn_pkg::P2_PSM_LSB +: 3];
    end
    else if (g == vicpn_pkg::SRC_CMP)
    begin : g_cmp
      assign src_lvl[g*3 +: 3] = prio2_q[vicpn_pkg::P2_CMP_LSB +: 3];
    end
    else if (g == vicpn_pkg::SRC_PWM)
    begin : g_pwm
      assign src_lvl[g*3 +: 3] = prio3_q[vicpn_pkg::P3_PWM_LSB +: 3];
    end
    else if (g == vicpn_pkg::SRC_LA1)
    begin : g_la1
      assign src_lvl[g*3 +: 3] = prio3_q[vicpn_pkg::P3_LA1_LSB +: 3];
    end
    else
    begin : g_oth
      assign src_lvl[g*3 +: 3] = other_prio[g*3 +: 3];
    end
  end

  // Per kind: arbitration, vector word, in-service register
  for (genvar k = 0; k < vicpn_pkg::NUM_K; k++)
  begin : g_kind
    // Control bit k is the nesting enable of kind k
    assign sel[k] = pick((k == vicpn_pkg::K_IRQ) ? irq_req : fiq_req,
                         src_lvl, nest_q[k], stan_q[k]);
    // Base in [22:7], index in [6:2], zeros elsewhere
    assign vec[k] = {9'h000, base_q, sel[k].idx, 2'h0};

    // Clear the lowest set bit on write; vector read sets, set wins
    always_comb
    begin
      stan_d[k] = stan_q[k];
      if (wr_acc && paddr == vicpn_pkg::ADDR_STAN[k])
      begin
        stan_d[k] = stan_q[k] & (stan_q[k] - 8'h01);
      end
      if (rd_acc && paddr == vicpn_pkg::ADDR_VEC[k] && nest_q[k] && cap_q[k].valid)
      begin
        stan_d[k][cap_q[k].level] = 1'b1;
      end
    end

    // In-service register
    always_ff @(posedge core_clk)
    begin
      if (sys_rst)
      begin
        stan_q[k] <= vicpn_pkg::RST_STAN;
      end
      else
      begin
        stan_q[k] <= stan_d[k];
      end
    end
  end

  // Priority registers, reserved bits held at zero
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      prio2_q <= vicpn_pkg::RST_PRIO;
      prio3_q <= vicpn_pkg::RST_PRIO;
    end
    else if (wr_acc && paddr == vicpn_pkg::ADDR_PRIO2)
    begin
      prio2_q <= pwdata & vicpn_pkg::PRIO2_MASK;
    end
    else if (wr_acc && paddr == vicpn_pkg::ADDR_PRIO3)
    begin
      prio3_q <= pwdata & vicpn_pkg::PRIO3_MASK;
    end
  end

  // Vector base and nesting control
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      base_q <= vicpn_pkg::RST_BASE;
      nest_q <= vicpn_pkg::RST_NEST;
    end
    else if (wr_acc && paddr == vicpn_pkg::ADDR_BASE)
    begin
      base_q <= pwdata[vicpn_pkg::BASE_W-1:0];
    end
    else if (wr_acc && paddr == vicpn_pkg::ADDR_NEST)
    begin
      nest_q <= pwdata[1:0];
    end
  end

  // Read data and error captured in the setup cycle
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
      cap_q   <= '0;
    end
    else if (setup)
    begin
      cap_q   <= sel;
      pslverr <= 1'b0;
      if (paddr == vicpn_pkg::ADDR_BASE)
      begin
        prdata <= {16'h0000, base_q};
      end
      else if (paddr == vicpn_pkg::ADDR_IVEC)
      begin
        prdata <= vec[vicpn_pkg::K_IRQ];
      end
      else if (paddr == vicpn_pkg::ADDR_PRIO2)
      begin
        prdata <= prio2_q;
      end
      else if (paddr == vicpn_pkg::ADDR_PRIO3)
      begin
        prdata <= prio3_q;
      end
      else if (paddr == vicpn_pkg::ADDR_NEST)
      begin
        prdata <= {30'h0000_0000, nest_q};
      end
      else if (paddr == vicpn_pkg::ADDR_ISTAN)
      begin
        prdata <= {24'h00_0000, stan_q[vicpn_pkg::K_IRQ]};
      end
      else if (paddr == vicpn_pkg::ADDR_FVEC)
      begin
        prdata <= vec[vicpn_pkg::K_FIQ];
      end
      else if (paddr == vicpn_pkg::ADDR_FSTAN)
      begin
        prdata <= {24'h00_0000, stan_q[vicpn_pkg::K_FIQ]};
      end
      else
      begin
        // Unmapped address answers with an error
        prdata  <= 32'h0000_0000;
        pslverr <= 1'b1;
      end
    end
  end

  // Core lines; a fast request that wins arbitration always holds off the normal line
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      core_irq_q <= 1'b0;
      core_fiq_q <= 1'b0;
    end
    else
    begin
      core_fiq_q <= sel[vicpn_pkg::K_FIQ].valid;
      core_irq_q <= sel[vicpn_pkg::K_IRQ].valid && !sel[vicpn_pkg::K_FIQ].valid;
    end
  end

  assign core_irq = core_irq_q;
  assign core_fiq = core_fiq_q;

  // Checks
  prio2_write_a : assert property (@(posedge core_clk) disable iff (sys_rst)
    (wr_acc && paddr == vicpn_pkg::ADDR_PRIO2) |=> prio2_q == ($past(pwdata) & vicpn_pkg::PRIO2_MASK))
    else $error("Set two priority write not stored");

  prio3_reserved_a : assert property (@(posedge core_clk) disable iff (sys_rst)
    (prio3_q & ~vicpn_pkg::PRIO3_MASK) == 32'h0000_0000)
    else $error("Set three reserved bits not zero");

  irq_clear_one_a : assert property (@(posedge core_clk) disable iff (sys_rst)
    (wr_acc && paddr == vicpn_pkg::ADDR_ISTAN && !(rd_acc))
    |=> stan_q[0] == ($past(stan_q[0]) & ~($past(stan_q[0]) & (~$past(stan_q[0]) + 8'h01))))
    else $error("Normal in-service write cleared wrong bits");

  fiq_clear_one_a : assert property (@(posedge core_clk) disable iff (sys_rst)
    (wr_acc && paddr == vicpn_pkg::ADDR_FSTAN)
    |=> stan_q[1] == ($past(stan_q[1]) & ~($past(stan_q[1]) & (~$past(stan_q[1]) + 8'h01))))
    else $error("Fast in-service write cleared wrong bits");

  irq_set_level_a : assert property (@(posedge core_clk) disable iff (sys_rst)
    (rd_acc && paddr == vicpn_pkg::ADDR_IVEC && nest_q[0] && cap_q[0].valid)
    |=> stan_q[0][$past(cap_q[0].level)])
    else $error("Normal vector read did not set level bit");

  fiq_nonest_hold_a : assert property (@(posedge core_clk) disable iff (sys_rst)
    (!nest_q[1] && !(wr_acc && paddr == vicpn_pkg::ADDR_FSTAN)) |=> $stable(stan_q[1]) || $past(nest_q[1]))
    else $error("Fast in-service changed with nesting off");

  fiq_first_a : assert property (@(posedge core_clk) disable iff (sys_rst)
    core_fiq_q |-> !core_irq_q)
    else $error("Normal line raised beside fast line");

  fvec_format_a : assert property (@(posedge core_clk) disable iff (sys_rst)
    (setup && paddr == vicpn_pkg::ADDR_FVEC)
    |=> prdata[31:23] == 9'h000 && prdata[1:0] == 2'h0 && prdata[22:7] == $past(base_q))
    else $error("Fast vector word badly formed");

  irq_block_a : assert property (@(posedge core_clk) disable iff (sys_rst)
    (sel[0].valid && nest_q[0] && stan_q[0] != 8'h00)
    |-> (8'h01 << sel[0].level) < (stan_q[0] & (~stan_q[0] + 8'h01)))
    else $error("Blocked normal level won arbitration");

  timer2_index_a : assert property (@(posedge core_clk) disable iff (sys_rst)
    (sel[1].valid && fiq_req == (28'h000_0001 << vicpn_pkg::SRC_TIMER2)) |-> sel[1].idx == 5'h04)
    else $error("Timer 2 index not encoded as four");

  fiq_set_level_a : assert property (@(posedge core_clk) disable iff (sys_rst)
    (rd_acc && paddr == vicpn_pkg::ADDR_FVEC && nest_q[1] && cap_q[1].valid)
    |=> stan_q[1][$past(cap_q[1].level)])
    else $error("Fast vector read did not set level bit");

  fiq_block_a : assert property (@(posedge core_clk) disable iff (sys_rst)
    (sel[1].valid && nest_q[1] && stan_q[1] != 8'h00)
    |-> (8'h01 << sel[1].level) < (stan_q[1] & (~stan_q[1] + 8'h01)))
    else $error("Blocked fast level won arbitration");

  irq_nonest_hold_a : assert property (@(posedge core_clk) disable iff (sys_rst)
    (!nest_q[0] && !(wr_acc && paddr == vicpn_pkg::ADDR_ISTAN)) |=> $stable(stan_q[0]))
    else $error("Normal in-service changed with nesting off");

  ivec_format_a : assert property (@(posedge core_clk) disable iff (sys_rst)
    (setup && paddr == vicpn_pkg::ADDR_IVEC)
    |=> prdata[22:7] == $past(base_q) && prdata[6:2] == $past(sel[0].idx)
        && prdata[31:23] == 9'h000 && prdata[1:0] == 2'h0)
    else $error("Normal vector word badly formed");

  base_read_a : assert property (@(posedge core_clk) disable iff (sys_rst)
    (setup && paddr == vicpn_pkg::ADDR_BASE) |=> prdata == {16'h0000, $past(base_q)})
    else $error("Vector base read badly formed");

  prio3_write_a : assert property (@(posedge core_clk) disable iff (sys_rst)
    (wr_acc && paddr == vicpn_pkg::ADDR_PRIO3) |=> prio3_q == ($past(pwdata) & vicpn_pkg::PRIO3_MASK))
    else $error("Set three priority write not stored");

  nest_write_a : assert property (@(posedge core_clk) disable iff (sys_rst)
    (wr_acc && paddr == vicpn_pkg::ADDR_NEST) |=> nest_q == $past(pwdata[1:0]))
    else $error("Nesting control write not stored");

  fiq_follow_a : assert property (@(posedge core_clk) disable iff (sys_rst)
    sel[1].valid |=> core_fiq_q)
    else $error("Fast request not delivered to core");

  irq_follow_a : assert property (@(posedge core_clk) disable iff (sys_rst)
    (sel[0].valid && !sel[1].valid) |=> core_irq_q)
    else $error("Normal request not delivered to core");

endmodule : vicpn_top

// ---- verif/vicpn_src_model.sv ----
`timescale 1ns/1ps
// Peripheral sources on the far side, plus a watch on the core request lines
module vicpn_src_model (
  input  wire logic                          core_clk,
  input  wire logic                          sys_rst,
  input  wire logic [vicpn_pkg::NUM_SRC-1:0] irq_cmd,
  input  wire logic [vicpn_pkg::NUM_SRC-1:0] fiq_cmd,
  input  wire logic                          core_irq,
  input  wire logic                          core_fiq,
  output logic      [vicpn_pkg::NUM_SRC-1:0] irq_req,
  output logic      [vicpn_pkg::NUM_SRC-1:0] fiq_req,
  output logic                               overlap_q
);

  // Request levels launched just after an edge, quiet during reset
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      irq_req <= '0;
      fiq_req <= '0;
    end
    else
    begin
      irq_req <= irq_cmd;
      fiq_req <= fiq_cmd;
    end
  end

  // Sticky flag: core saw both request lines at once
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      overlap_q <= 1'b0;
    else if (core_irq && core_fiq)
      overlap_q <= 1'b1;
  end

endmodule : vicpn_src_model

// ---- verif/vic_priority_nesting_tb.sv ----
`timescale 1ns/1ps
module vic_priority_nesting_tb;
  // One table row: address, write data, expected read
  typedef struct {
    logic [31:0] a;
    logic [31:0] w;
    logic [31:0] e;
  } vicpn_row_t;

  localparam logic [31:0] BASE_V = 32'h0000_1234;    // Vector base used after the table
  logic                                   core_clk;   // Core clock
  logic                                   sys_rst;    // Sync reset
  logic                                   psel;       // Bus select
  logic                                   penable;    // Bus access phase
  logic                                   pwrite;     // Bus direction
  logic [31:0]                            paddr;      // Bus address
  logic [31:0]                            pwdata;     // Bus write data
  logic [31:0]                            prdata;     // Bus read data
  logic                                   pready;     // Bus ready
  logic                                   pslverr;    // Bus error
  logic [vicpn_pkg::NUM_SRC-1:0]          irq_cmd;    // Normal levels wanted
  logic [vicpn_pkg::NUM_SRC-1:0]          fiq_cmd;    // Fast levels wanted
  logic [vicpn_pkg::NUM_SRC-1:0]          irq_req;    // Normal requests
  logic [vicpn_pkg::NUM_SRC-1:0]          fiq_req;    // Fast requests
  logic [vicpn_pkg::NUM_SRC*3-1:0]        other_prio; // Levels of other sources
  logic                                   core_irq;   // Core normal line
  logic                                   core_fiq;   // Core fast line
  logic                                   overlap_q;  // Both lines seen high
  int                                     err_total;  // Mismatches
  int                                     total_checks; // Comparisons
  logic [31:0]                            rd_v;       // Last read data
  logic                                   rd_e;       // Last error flag
  vicpn_row_t                             rows [5];   // Register table
  logic [31:0]                            rst_a [8];  // Addresses checked at reset

  vicpn_top i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_req(irq_req),
    .fiq_req(fiq_req), .other_prio(other_prio), .core_irq(core_irq), .core_fiq(core_fiq));

  vicpn_src_model i_src (.core_clk(core_clk), .sys_rst(sys_rst), .irq_cmd(irq_cmd), .fiq_cmd(fiq_cmd),
    .core_irq(core_irq), .core_fiq(core_fiq), .irq_req(irq_req), .fiq_req(fiq_req), .overlap_q(overlap_q));

  // Clock
  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  // Verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask : chk

  // One bus transfer: setup, then access held until ready
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    // Wait for ready; only the watchdog ends a hang
    do
    begin
      @(posedge core_clk);
    end
    while (pready !== 1'b1);
    rd_v = prdata;
    rd_e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : bus

  // Read and compare
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd_v);
  endtask : rd_chk

  // Set request levels of one kind
  task automatic req(input int k, input logic [vicpn_pkg::NUM_SRC-1:0] m);
    @(posedge core_clk);
    if (k == vicpn_pkg::K_IRQ)
      irq_cmd <= m;
    else
      fiq_cmd <= m;
  endtask : req

  // Core lines after they settle: kind k shows x, the other is low
  task automatic core_chk(input int k, input logic x);
    repeat (4) @(posedge core_clk);
    #1;
    chk("core normal", {31'h0, (k == vicpn_pkg::K_IRQ) && x}, {31'h0, core_irq});
    chk("core fast", {31'h0, (k == vicpn_pkg::K_FIQ) && x}, {31'h0, core_fiq});
  endtask : core_chk

  // One-hot source mask
  function automatic logic [vicpn_pkg::NUM_SRC-1:0] sb(input int i);
    sb = '0;
    sb[i] = 1'b1;
  endfunction : sb

  // Expected vector word for a winning source
  function automatic logic [31:0] vec(input int i);
    vec = (BASE_V << vicpn_pkg::VEC_BASE_LSB) | (32'(i) << vicpn_pkg::VEC_IDX_LSB);
  endfunction : vec

  // Watchdog
  initial
  begin
    repeat (5000) @(posedge core_clk);
    err_total++;
    finish_test();
  end

  // Main sequence
  initial
  begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    irq_cmd = '0;
    fiq_cmd = '0;
    other_prio = {vicpn_pkg::NUM_SRC{3'h7}};
    err_total = 0;
    total_checks = 0;
    rows[0] = '{vicpn_pkg::ADDR_PRIO2, 32'hFFFF_FFFF, 32'h7777_7777};
    rows[1] = '{vicpn_pkg::ADDR_PRIO3, 32'hFFFF_FFFF, 32'h0000_0077};
    rows[2] = '{vicpn_pkg::ADDR_NEST, 32'h0000_0003, 32'h0000_0003};
    rows[3] = '{vicpn_pkg::ADDR_BASE, 32'hFFFF_FFFF, 32'h0000_FFFF};
    rows[4] = '{vicpn_pkg::ADDR_BASE, 32'h0001_1234, BASE_V};
    rst_a = '{vicpn_pkg::ADDR_BASE, vicpn_pkg::ADDR_PRIO2, vicpn_pkg::ADDR_PRIO3, vicpn_pkg::ADDR_NEST,
      vicpn_pkg::ADDR_ISTAN, vicpn_pkg::ADDR_FSTAN, vicpn_pkg::ADDR_IVEC, vicpn_pkg::ADDR_FVEC};
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    // Reset values, then an unmapped place
    foreach (rst_a[i])
      rd_chk(rst_a[i], 32'h0000_0000, "reset value");
    bus(1'b0, 32'hFFFF_0040, 32'h0000_0000);
    chk("unmapped error", 32'h0000_0001, {31'h0, rd_e});
    $display("test reset and unmapped done");
    // Table rows: write then read back
    foreach (rows[i])
    begin
      bus(1'b1, rows[i].a, rows[i].w);
      rd_chk(rows[i].a, rows[i].e, "register field");
    end
    $display("test register table done");
    // Nesting per kind: set, block, stack two levels, clear one at a time
    for (int k = 0; k < vicpn_pkg::NUM_K; k++)
    begin
      bus(1'b1, vicpn_pkg::ADDR_PRIO2, 32'h0000_0350);
      req(k, sb(vicpn_pkg::SRC_PIN0) | sb(vicpn_pkg::SRC_CMP));
      core_chk(k, 1'b1);
      rd_chk(vicpn_pkg::ADDR_VEC[k], vec(vicpn_pkg::SRC_CMP), "vector level 3");
      rd_chk(vicpn_pkg::ADDR_STAN[k], 32'h0000_0008, "in service 3");
      core_chk(k, 1'b0);
      req(k, sb(vicpn_pkg::SRC_PIN0) | sb(vicpn_pkg::SRC_CMP) | sb(vicpn_pkg::SRC_SPI));
      core_chk(k, 1'b1);
      rd_chk(vicpn_pkg::ADDR_VEC[k], vec(vicpn_pkg::SRC_SPI), "vector level 0");
      rd_chk(vicpn_pkg::ADDR_STAN[k], 32'h0000_0009, "in service 0 and 3");
      bus(1'b1, vicpn_pkg::ADDR_STAN[k], 32'h0000_00FF);
      rd_chk(vicpn_pkg::ADDR_STAN[k], 32'h0000_0008, "first clear");
      bus(1'b1, vicpn_pkg::ADDR_STAN[k], 32'h0000_00FF);
      rd_chk(vicpn_pkg::ADDR_STAN[k], 32'h0000_0000, "second clear");
      req(k, '0);
      core_chk(k, 1'b0);
    end
    $display("test nesting done");
    // Equal levels: lowest index wins
    bus(1'b1, vicpn_pkg::ADDR_PRIO2, 32'h0000_0220);
    req(vicpn_pkg::K_IRQ, sb(vicpn_pkg::SRC_PIN0) | sb(vicpn_pkg::SRC_CMP));
    core_chk(vicpn_pkg::K_IRQ, 1'b1);
    rd_chk(vicpn_pkg::ADDR_IVEC, vec(vicpn_pkg::SRC_PIN0), "equal level vector");
    rd_chk(vicpn_pkg::ADDR_ISTAN, 32'h0000_0004, "in service 2");
    bus(1'b1, vicpn_pkg::ADDR_ISTAN, 32'h0000_00FF);
    req(vicpn_pkg::K_IRQ, '0);
    $display("test equal levels done");
    // Timer 2 as fast winner, its level from the other-source input
    other_prio[vicpn_pkg::SRC_TIMER2*3 +: 3] <= 3'h1;
    req(vicpn_pkg::K_FIQ, sb(vicpn_pkg::SRC_TIMER2));
    req(vicpn_pkg::K_FIQ, sb(vicpn_pkg::SRC_TIMER2) | sb(vicpn_pkg::SRC_PIN0));
    core_chk(vicpn_pkg::K_FIQ, 1'b1);
    rd_chk(vicpn_pkg::ADDR_FVEC, vec(32'h0000_0004), "timer 2 vector");
    rd_chk(vicpn_pkg::ADDR_FSTAN, 32'h0000_0002, "in service 1");
    bus(1'b1, vicpn_pkg::ADDR_FSTAN, 32'h0000_00FF);
    req(vicpn_pkg::K_FIQ, '0);
    $display("test timer 2 done");
    // Nesting off: no levels, no in-service, fast beats normal
    bus(1'b1, vicpn_pkg::ADDR_NEST, 32'h0000_0000);
    bus(1'b1, vicpn_pkg::ADDR_PRIO2, 32'h0000_0250);
    req(vicpn_pkg::K_IRQ, sb(vicpn_pkg::SRC_PIN0) | sb(vicpn_pkg::SRC_CMP));
    core_chk(vicpn_pkg::K_IRQ, 1'b1);
    rd_chk(vicpn_pkg::ADDR_IVEC, vec(vicpn_pkg::SRC_PIN0), "no priority vector");
    rd_chk(vicpn_pkg::ADDR_ISTAN, 32'h0000_0000, "no in service");
    core_chk(vicpn_pkg::K_IRQ, 1'b1);
    req(vicpn_pkg::K_FIQ, sb(vicpn_pkg::SRC_CMP));
    core_chk(vicpn_pkg::K_FIQ, 1'b1);
    chk("both lines high", 32'h0000_0000, {31'h0, overlap_q});
    req(vicpn_pkg::K_IRQ, '0);
    req(vicpn_pkg::K_FIQ, '0);
    $display("test nesting off done");
    // Reset in mid-run returns registers to zero
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd_chk(vicpn_pkg::ADDR_PRIO2, 32'h0000_0000, "second reset set two");
    rd_chk(vicpn_pkg::ADDR_PRIO3, 32'h0000_0000, "second reset set three");
    rd_chk(vicpn_pkg::ADDR_BASE, 32'h0000_0000, "second reset base");
    $display("test second reset done");
    finish_test();
  end

endmodule : vic_priority_nesting_tb
